/* include/sfb_params.svh */
// constants for the status flag and bank select block
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH
`define SFB_VEC_EMB_BIT    7
`define SFB_VEC_ERB_BIT    6
`define SFB_BANK_MAIN      4'h0
`define SFB_BANK_DISP      4'h1
`define SFB_BANK_PERIPH    4'hF
`define SFB_LOW_LIMIT      8'h7F
`define SFB_HIGH_BASE      8'h80
`define SFB_SMB_RST        4'h0
`define SFB_SRB_RST        2'h0
`define SFB_CARRY_RST      1'b0
`define SFB_PSW_CARRY_BIT  3
`define SFB_PSW_EMB_BIT    1
`define SFB_PSW_ERB_BIT    0
`endif

/* include/sfb_pkg.sv */
// types shared by the status flag and bank select block
package sfb_pkg;
   // carry operations requested by the execution unit
   typedef enum logic [3:0] {
      SFB_C_NONE,
      SFB_C_ARITH,
      SFB_C_SET,
      SFB_C_CLEAR,
      SFB_C_INVERT,
      SFB_C_LOAD_BIT,
      SFB_C_AND,
      SFB_C_OR,
      SFB_C_XOR,
      SFB_C_RESTORE
   } sfb_carry_op_t;
   // flag bit operations
   typedef enum logic [1:0] {
      SFB_F_NONE,
      SFB_F_SET,
      SFB_F_CLEAR
   } sfb_flag_op_t;
endpackage

/* rtl/sfb_status_flags.sv */
// status flags, carry and bank select logic of the 4-bit core
//
// Contract
// - register bank enable low forces working register bank 0
// - register bank enable high uses the register bank select value 0 to 3
// - skip condition flags follow the skip condition set by execution
// - skip flags readable only by 8-bit read, bit and nibble writes ignored
// - add or subtract with carry sets carry on overflow or borrow, else clears
// - reset does not initialise the carry flag; the code resets it to 0
// - only the listed carry operations change the carry flag
// - set, clear and invert carry without touching other status bits
// - bit test on carry skips next instruction when carry is 1
// - bit transfer copies carry to a memory bit or a memory bit to carry
// - AND, OR, XOR of memory bit with carry written back to carry
// - carry saved with status word on interrupt entry, restored on return
// - memory bank enable 1 reaches all RAM, 0 only restricted locations
// - memory bank select gives upper four address bits, bank 0, 1 or 15
// - display RAM in bank 1 accessible only by 8-bit operations
// - internal reset loads memory bank enable from bit 7 of word 0000H; the code resets it to 0, vec_load_in loads it
// - vectored interrupt loads memory bank enable from bit 7 of vector entry
// - memory bank enable saved on interrupt and restored after service
// - bit set and clear change both enables whatever the bank select is
// - register bank enable loaded from bit 6 of reset word or vector entry; the code resets it to 0, vec_load_in loads it
// - enable 0 direct addressing reaches 000H-07FH and F80H-FFFH only
// - enable 1 maps select 0, 1, 15 to 000H-0FFH, 100H-1FFH, F80H-FFFH
`timescale 1ns/1ns
`include "sfb_params.svh"

module sfb_status_flags (
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  vec_load_in,
   input  wire logic [7:0]            vec_word_in,
   input  wire logic                  int_entry_in,
   input  wire logic                  int_return_in,
   input  wire logic [3:0]            psw_restore_in,
   input  wire sfb_pkg::sfb_carry_op_t carry_op_in,
   input  wire logic                  arith_carry_in,
   input  wire logic                  mem_bit_in,
   input  wire logic                  bit_test_carry_in,
   input  wire sfb_pkg::sfb_flag_op_t emb_op_in,
   input  wire sfb_pkg::sfb_flag_op_t erb_op_in,
   input  wire logic                  smb_wr_in,
   input  wire logic [3:0]            smb_val_in,
   input  wire logic                  srb_wr_in,
   input  wire logic [1:0]            srb_val_in,
   input  wire logic                  skip_wr_in,
   input  wire logic [2:0]            skip_val_in,
   input  wire logic                  psw_small_wr_in,
   input  wire logic                  acc_valid_in,
   input  wire logic [7:0]            acc_addr_in,
   input  wire logic                  acc_indirect_in,
   input  wire logic                  acc_wide_in,
   output logic                       carry_out,
   output logic                       emb_out,
   output logic                       erb_out,
   output logic [3:0]                 smb_out,
   output logic [1:0]                 work_bank_out,
   output logic [2:0]                 skip_flags_out,
   output logic                       skip_next_out,
   output logic [3:0]                 psw_save_out,
   output logic [11:0]                ram_addr_out,
   output logic                       acc_ok_out
);

   logic        carry_ff;
   logic        emb_ff;
   logic        erb_ff;
   logic [3:0]  smb_ff;
   logic [1:0]  srb_ff;
   logic [2:0]  skip_ff;
   logic        skip_next_ff;
   logic [3:0]  psw_save_ff;
   logic [1:0]  work_bank_ff;
   logic [11:0] ram_addr_ff;
   logic        acc_ok_ff;
   logic        nxt_carry;
   logic [3:0]  nxt_bank;
   logic        nxt_ok;

   ////////////////////////////////////////////////////////////////////////////
   // carry flag next value
   always_comb begin
      nxt_carry = carry_ff;
      case (carry_op_in)
         sfb_pkg::SFB_C_ARITH:    nxt_carry = arith_carry_in;
         sfb_pkg::SFB_C_SET:      nxt_carry = 1'b1;
         sfb_pkg::SFB_C_CLEAR:    nxt_carry = 1'b0;
         sfb_pkg::SFB_C_INVERT:   nxt_carry = ~carry_ff;
         sfb_pkg::SFB_C_LOAD_BIT: nxt_carry = mem_bit_in;
         sfb_pkg::SFB_C_AND:      nxt_carry = carry_ff & mem_bit_in;
         sfb_pkg::SFB_C_OR:       nxt_carry = carry_ff | mem_bit_in;
         sfb_pkg::SFB_C_XOR:      nxt_carry = carry_ff ^ mem_bit_in;
         sfb_pkg::SFB_C_RESTORE:
            nxt_carry = psw_restore_in[`SFB_PSW_CARRY_BIT];
         default:                 nxt_carry = carry_ff;
      endcase
      if (int_return_in) begin
         nxt_carry = psw_restore_in[`SFB_PSW_CARRY_BIT];
      end
   end

   // carry register; reset only forces a known value for simulation, software
   // must not rely on it
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         carry_ff <= `SFB_CARRY_RST;
      end else begin
         carry_ff <= nxt_carry;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory bank enable: vector load, restore, bit ops
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         emb_ff <= 1'b0;
      end else if (vec_load_in) begin
         emb_ff <= vec_word_in[`SFB_VEC_EMB_BIT];
      end else if (int_return_in) begin
         emb_ff <= psw_restore_in[`SFB_PSW_EMB_BIT];
      end else if (emb_op_in == sfb_pkg::SFB_F_SET) begin
         emb_ff <= 1'b1;
      end else if (emb_op_in == sfb_pkg::SFB_F_CLEAR) begin
         emb_ff <= 1'b0;
      end
   end

   // register bank enable: vector load, restore, bit ops
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         erb_ff <= 1'b0;
      end else if (vec_load_in) begin
         erb_ff <= vec_word_in[`SFB_VEC_ERB_BIT];
      end else if (int_return_in) begin
         erb_ff <= psw_restore_in[`SFB_PSW_ERB_BIT];
      end else if (erb_op_in == sfb_pkg::SFB_F_SET) begin
         erb_ff <= 1'b1;
      end else if (erb_op_in == sfb_pkg::SFB_F_CLEAR) begin
         erb_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bank select registers, cleared by reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         smb_ff <= `SFB_SMB_RST;
         srb_ff <= `SFB_SRB_RST;
      end else begin
         if (smb_wr_in) begin
            smb_ff <= smb_val_in;
         end
         if (srb_wr_in) begin
            srb_ff <= srb_val_in;
         end
      end
   end

   // working register bank from enable and select
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         work_bank_ff <= 2'h0;
      end else begin
         work_bank_ff <= erb_ff ? srb_ff : 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // skip flags: hardware update only; psw_small_wr_in has no path here
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         skip_ff <= 3'h0;
      end else if (skip_wr_in) begin
         skip_ff <= skip_val_in;
      end
   end

   // skip request from a carry bit test
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         skip_next_ff <= 1'b0;
      end else begin
         skip_next_ff <= bit_test_carry_in & carry_ff;
      end
   end

   // status bits captured for the stack at interrupt entry
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         psw_save_ff <= 4'h0;
      end else if (int_entry_in) begin
         psw_save_ff <= {carry_ff, 1'b0, emb_ff, erb_ff};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // RAM address formation and access check
   always_comb begin
      nxt_bank = smb_ff;
      nxt_ok   = 1'b1;
      if (!emb_ff) begin
         if (acc_indirect_in) begin
            nxt_bank = `SFB_BANK_MAIN;
         end else if (acc_addr_in <= `SFB_LOW_LIMIT) begin
            nxt_bank = `SFB_BANK_MAIN;
         end else begin
            nxt_bank = `SFB_BANK_PERIPH;
         end
      end else begin
         case (smb_ff)
            `SFB_BANK_MAIN:   nxt_ok = 1'b1;
            `SFB_BANK_DISP:   nxt_ok = acc_wide_in;
            `SFB_BANK_PERIPH: nxt_ok = (acc_addr_in >= `SFB_HIGH_BASE);
            default:          nxt_ok = 1'b0;
         endcase
      end
      if (acc_wide_in && acc_addr_in[0]) begin
         nxt_ok = 1'b0;
      end
   end

   // registered address and permit
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ram_addr_ff <= 12'h000;
         acc_ok_ff   <= 1'b0;
      end else begin
         ram_addr_ff <= {nxt_bank, acc_addr_in};
         acc_ok_ff   <= acc_valid_in & nxt_ok;
      end
   end

   assign carry_out      = carry_ff;
   assign emb_out        = emb_ff;
   assign erb_out        = erb_ff;
   assign smb_out        = smb_ff;
   assign work_bank_out  = work_bank_ff;
   assign skip_flags_out = skip_ff;
   assign skip_next_out  = skip_next_ff;
   assign psw_save_out   = psw_save_ff;
   assign ram_addr_out   = ram_addr_ff;
   assign acc_ok_out     = acc_ok_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_vec;
      vec_load_in;
   endsequence

   chk_bank_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      !erb_ff |=> work_bank_ff == 2'h0) else $error("bank not 0");
   chk_bank_sel: assert property (@(posedge clk_in) disable iff (rst_in)
      erb_ff |=> work_bank_ff == $past(srb_ff)) else $error("bank mismatch");
   chk_arith_carry: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_ARITH && !int_return_in
      |=> carry_ff == $past(arith_carry_in)) else $error("arith carry");
   chk_carry_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_NONE && !int_return_in
      |=> $stable(carry_ff)) else $error("carry changed");
   chk_carry_invert: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_INVERT && !int_return_in
      |=> carry_ff != $past(carry_ff)) else $error("invert failed");
   chk_skip_carry: assert property (@(posedge clk_in) disable iff (rst_in)
      bit_test_carry_in |=> skip_next_ff == $past(carry_ff)) else $error("skip wrong");
   chk_vec_emb: assert property (@(posedge clk_in) disable iff (rst_in)
      s_vec |=> emb_ff == $past(vec_word_in[7]) && erb_ff == $past(vec_word_in[6]))
      else $error("vector load");
   chk_skip_ro: assert property (@(posedge clk_in) disable iff (rst_in)
      !skip_wr_in |=> $stable(skip_ff)) else $error("skip flags written");
   chk_low_bank: assert property (@(posedge clk_in) disable iff (rst_in)
      !emb_ff && !acc_indirect_in && acc_addr_in[7]
      |=> ram_addr_ff[11:8] == 4'hF) else $error("bank 15 expected");

   // return from interrupt as a named step
   sequence s_ret;
      int_return_in;
   endsequence

   // set carry drives the flag high
   chk_carry_set: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_SET && !int_return_in
      |=> carry_ff) else $error("set carry failed");

   // clear carry drives the flag low
   chk_carry_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_CLEAR && !int_return_in
      |=> !carry_ff) else $error("clear carry failed");

   // bit transfer copies the memory bit into carry
   chk_carry_load: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_LOAD_BIT && !int_return_in
      |=> carry_ff == $past(mem_bit_in)) else $error("bit load failed");

   // boolean and with the memory bit
   chk_carry_and: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_AND && !int_return_in
      |=> carry_ff == ($past(carry_ff) & $past(mem_bit_in))) else $error("and failed");

   // boolean or with the memory bit
   chk_carry_or: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_OR && !int_return_in
      |=> carry_ff == ($past(carry_ff) | $past(mem_bit_in))) else $error("or failed");

   // boolean exclusive or with the memory bit
   chk_carry_xor: assert property (@(posedge clk_in) disable iff (rst_in)
      carry_op_in == sfb_pkg::SFB_C_XOR && !int_return_in
      |=> carry_ff == ($past(carry_ff) ^ $past(mem_bit_in))) else $error("xor failed");

   // return from interrupt restores carry over any carry operation
   chk_carry_restore: assert property (@(posedge clk_in) disable iff (rst_in)
      s_ret |=> carry_ff == $past(psw_restore_in[3])) else $error("carry restore");

   // return from interrupt restores the memory bank enable
   chk_emb_restore: assert property (@(posedge clk_in) disable iff (rst_in)
      s_ret and !vec_load_in
      |=> emb_ff == $past(psw_restore_in[1])) else $error("emb restore");

   // bit set reaches the memory bank enable whatever the select value
   chk_emb_set: assert property (@(posedge clk_in) disable iff (rst_in)
      emb_op_in == sfb_pkg::SFB_F_SET && !vec_load_in && !int_return_in
      |=> emb_ff) else $error("emb set failed");

   // bit clear reaches the memory bank enable whatever the select value
   chk_emb_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      emb_op_in == sfb_pkg::SFB_F_CLEAR && !vec_load_in && !int_return_in
      |=> !emb_ff) else $error("emb clear failed");

   // bit set reaches the register bank enable
   chk_erb_set: assert property (@(posedge clk_in) disable iff (rst_in)
      erb_op_in == sfb_pkg::SFB_F_SET && !vec_load_in && !int_return_in
      |=> erb_ff) else $error("erb set failed");

   // bit clear reaches the register bank enable
   chk_erb_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      erb_op_in == sfb_pkg::SFB_F_CLEAR && !vec_load_in && !int_return_in
      |=> !erb_ff) else $error("erb clear failed");

   // interrupt entry captures carry and both enables
   chk_psw_capture: assert property (@(posedge clk_in) disable iff (rst_in)
      int_entry_in |=> psw_save_ff[3] == $past(carry_ff) && psw_save_ff[1] == $past(emb_ff)
      && psw_save_ff[0] == $past(erb_ff)) else $error("status capture");

   // display bank refuses narrow accesses
   chk_disp_narrow: assert property (@(posedge clk_in) disable iff (rst_in)
      emb_ff && smb_ff == 4'h1 && !acc_wide_in
      |=> !acc_ok_ff) else $error("narrow display access");

   // wide access on an odd address is refused
   chk_odd_wide: assert property (@(posedge clk_in) disable iff (rst_in)
      acc_wide_in && acc_addr_in[0] |=> !acc_ok_ff) else $error("odd wide access");

   // direct low addresses land in bank 0 while disabled
   chk_low_bank0: assert property (@(posedge clk_in) disable iff (rst_in)
      !emb_ff && !acc_indirect_in && !acc_addr_in[7]
      |=> ram_addr_ff[11:8] == 4'h0) else $error("bank 0 expected");

   // enabled accesses take the upper nibble from the select value
   chk_emb_bank: assert property (@(posedge clk_in) disable iff (rst_in)
      emb_ff |=> ram_addr_ff[11:8] == $past(smb_ff)) else $error("select nibble");

   // lower address byte passes straight through
   chk_addr_low: assert property (@(posedge clk_in) disable iff (rst_in)
      acc_valid_in |=> ram_addr_ff[7:0] == $past(acc_addr_in)) else $error("address byte");

   // hardware skip update is taken as given
   chk_skip_load: assert property (@(posedge clk_in) disable iff (rst_in)
      skip_wr_in |=> skip_ff == $past(skip_val_in)) else $error("skip update");

   // no request, no permit
   chk_no_valid: assert property (@(posedge clk_in) disable iff (rst_in)
      !acc_valid_in |=> !acc_ok_ff) else $error("permit without request");

   // a vector load alone leaves carry untouched
   chk_carry_vec: assert property (@(posedge clk_in) disable iff (rst_in)
      vec_load_in && carry_op_in == sfb_pkg::SFB_C_NONE && !int_return_in
      |=> $stable(carry_ff)) else $error("carry moved by vector");

   // peripheral bank refuses its lower half when enabled
   chk_peri_low: assert property (@(posedge clk_in) disable iff (rst_in)
      emb_ff && smb_ff == 4'hF && !acc_addr_in[7]
      |=> !acc_ok_ff) else $error("peripheral low half");

endmodule

/* dv/sfb_exec_model.sv */
// model of the execution unit side: vector word table and operand address
`timescale 1ns/1ns

module sfb_exec_model (
   input  wire logic [1:0] vec_idx_in,
   input  wire logic [7:0] raw_addr_in,
   output logic      [7:0] vec_word_out,
   output logic      [7:0] even_addr_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // vector table: reset word first, then interrupt entries
   always_comb begin
      case (vec_idx_in)
         2'h0:    vec_word_out = 8'h80;
         2'h1:    vec_word_out = 8'h41;
         2'h2:    vec_word_out = 8'hC2;
         default: vec_word_out = 8'h3F;
      endcase
   end
   // software keeps wide operands on even addresses
   assign even_addr_out = {raw_addr_in[7:1], 1'b0};
endmodule

/* dv/tb.sv */
// self-checking testbench for the status flag and bank select block
`timescale 1ns/1ns

module tb;
   logic clk_in, rst_in, vec_load_in, int_entry_in, int_return_in, arith_carry_in, mem_bit_in;
   logic bit_test_carry_in, smb_wr_in, srb_wr_in, skip_wr_in, psw_small_wr_in, acc_valid_in;
   logic acc_indirect_in, acc_wide_in, carry_out, emb_out, erb_out, skip_next_out, acc_ok_out;
   logic [7:0] vec_word_in, acc_addr_in, raw_addr, even_addr;
   logic [3:0] psw_restore_in, smb_val_in, smb_out, psw_save_out, rs;
   logic [2:0] skip_val_in, skip_flags_out;
   logic [1:0] srb_val_in, work_bank_out, vidx;
   logic [11:0] ram_addr_out;
   logic [12:0] x;
   logic ec, e;
   sfb_pkg::sfb_carry_op_t carry_op_in, op;
   sfb_pkg::sfb_flag_op_t emb_op_in, erb_op_in;
   int n_mismatch, cmp_count, cyc, i;
   integer seed;

   sfb_status_flags i_dut (.clk_in, .rst_in, .vec_load_in, .vec_word_in, .int_entry_in,
      .int_return_in, .psw_restore_in, .carry_op_in, .arith_carry_in, .mem_bit_in,
      .bit_test_carry_in, .emb_op_in, .erb_op_in, .smb_wr_in, .smb_val_in, .srb_wr_in,
      .srb_val_in, .skip_wr_in, .skip_val_in, .psw_small_wr_in, .acc_valid_in, .acc_addr_in,
      .acc_indirect_in, .acc_wide_in, .carry_out, .emb_out, .erb_out, .smb_out,
      .work_bank_out, .skip_flags_out, .skip_next_out, .psw_save_out, .ram_addr_out,
      .acc_ok_out);
   sfb_exec_model i_exec (.vec_idx_in(vidx), .raw_addr_in(raw_addr),
      .vec_word_out(vec_word_in), .even_addr_out(even_addr));

   ////////////////////////////////////////////////////////////////////////////////
   // expected carry after one operation
   function automatic logic nc(sfb_pkg::sfb_carry_op_t o, logic c, logic ac, logic mb);
      case (o)
         sfb_pkg::SFB_C_ARITH:    return ac;
         sfb_pkg::SFB_C_SET:      return 1'b1;
         sfb_pkg::SFB_C_CLEAR:    return 1'b0;
         sfb_pkg::SFB_C_INVERT:   return !c;
         sfb_pkg::SFB_C_LOAD_BIT: return mb;
         sfb_pkg::SFB_C_AND:      return c & mb;
         sfb_pkg::SFB_C_OR:       return c | mb;
         sfb_pkg::SFB_C_XOR:      return c ^ mb;
         default:                 return c;
      endcase
   endfunction
   // expected {ok, bank, address} of one data access
   function automatic logic [12:0] exp_acc(logic en, logic [3:0] s, logic [7:0] a, logic ind,
                                           logic w);
      logic ok;
      logic [3:0] b;
      ok = !(w && a[0]);
      b = s;
      if (!en) b = (ind || a < 8'h80) ? 4'h0 : 4'hF;
      else if (s == 4'h1) ok = ok && w;
      else if (s == 4'hF) ok = ok && a >= 8'h80;
      else if (s != 4'h0) ok = 1'b0;
      return {ok, b, a};
   endfunction
   // one comparison
   task automatic chk(string nm, logic [12:0] exp, logic [12:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // wait n edges, drop every strobe, let outputs settle
   task automatic fin(int n);
      repeat (n) @(posedge clk_in);
      {vec_load_in, int_entry_in, int_return_in, bit_test_carry_in} <= 4'h0;
      {smb_wr_in, srb_wr_in, skip_wr_in, psw_small_wr_in, acc_valid_in} <= 5'h0;
      carry_op_in <= sfb_pkg::SFB_C_NONE;
      emb_op_in <= sfb_pkg::SFB_F_NONE;
      erb_op_in <= sfb_pkg::SFB_F_NONE;
      #1;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // clock and cycle ceiling
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         final_report;
      end
   end
   // main sequence
   initial begin
      seed = 32'h24A0F594;
      {n_mismatch, cmp_count, cyc} = '0;
      {vec_load_in, int_entry_in, int_return_in, arith_carry_in, mem_bit_in} = '0;
      {bit_test_carry_in, smb_wr_in, srb_wr_in, skip_wr_in, psw_small_wr_in} = '0;
      {acc_valid_in, acc_indirect_in, acc_wide_in, acc_addr_in, raw_addr, vidx} = '0;
      {psw_restore_in, smb_val_in, srb_val_in, skip_val_in} = '0;
      carry_op_in = sfb_pkg::SFB_C_NONE;
      emb_op_in = sfb_pkg::SFB_F_NONE;
      erb_op_in = sfb_pkg::SFB_F_NONE;
      rst_in = 1'b1;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      // vector words load both enables
      for (i = 0; i < 4; i++) begin
         @(posedge clk_in) vidx <= 2'(i);
         @(posedge clk_in) vec_load_in <= 1'b1;
         fin(1);
         chk("emb", 13'(vec_word_in[7]), 13'(emb_out));
         chk("erb", 13'(vec_word_in[6]), 13'(erb_out));
      end
      // bit ops on enables, bank selects, working bank
      for (i = 0; i < 16; i++) begin
         @(posedge clk_in);
         srb_wr_in <= 1'b1;
         srb_val_in <= 2'(i);
         smb_wr_in <= 1'b1;
         smb_val_in <= (i % 3 == 0) ? 4'h0 : (i % 3 == 1) ? 4'h1 : 4'hF;
         erb_op_in <= i[2] ? sfb_pkg::SFB_F_SET : sfb_pkg::SFB_F_CLEAR;
         emb_op_in <= i[3] ? sfb_pkg::SFB_F_SET : sfb_pkg::SFB_F_CLEAR;
         fin(2);
         chk("emb", 13'(i[3]), 13'(emb_out));
         chk("erb", 13'(i[2]), 13'(erb_out));
         chk("bank", i[2] ? 13'(i[1:0]) : 13'h0, 13'(work_bank_out));
         chk("smb", 13'(smb_val_in), 13'(smb_out));
      end
      // skip flags follow execution, small writes ignored
      @(posedge clk_in) skip_wr_in <= 1'b1;
      skip_val_in <= 3'h5;
      fin(1);
      chk("skip", 13'h5, 13'(skip_flags_out));
      @(posedge clk_in) psw_small_wr_in <= 1'b1;
      skip_val_in <= 3'h2;
      fin(1);
      chk("skip", 13'h5, 13'(skip_flags_out));
      // carry operations in random order
      ec = 1'b0;
      for (i = 0; i < 60; i++) begin
         op = sfb_pkg::sfb_carry_op_t'(4'($unsigned($random(seed)) % 9));
         if (i == 0) op = sfb_pkg::SFB_C_SET;
         @(posedge clk_in) carry_op_in <= op;
         arith_carry_in <= 1'($random(seed));
         mem_bit_in <= 1'($random(seed));
         fin(1);
         ec = nc(op, ec, arith_carry_in, mem_bit_in);
         chk("carry", 13'(ec), 13'(carry_out));
         @(posedge clk_in) bit_test_carry_in <= 1'b1;
         fin(2);
         chk("skip_next", 13'(ec), 13'(skip_next_out));
      end
      // interrupt entry saves, return restores over a clashing carry op
      @(posedge clk_in) int_entry_in <= 1'b1;
      fin(1);
      rs = {ec, 1'b0, 1'b1, 1'b1};
      chk("psw_save", 13'(rs), 13'(psw_save_out));
      @(posedge clk_in) vec_load_in <= 1'b1;
      carry_op_in <= sfb_pkg::SFB_C_INVERT;
      fin(1);
      @(posedge clk_in) int_return_in <= 1'b1;
      psw_restore_in <= rs;
      carry_op_in <= sfb_pkg::SFB_C_INVERT;
      fin(1);
      chk("restore", 13'(rs), 13'({carry_out, 1'b0, emb_out, erb_out}));
      // data accesses under both enables and banks 0, 1 and 15
      for (i = 0; i < 80; i++) begin
         e = 1'($random(seed));
         @(posedge clk_in) emb_op_in <= e ? sfb_pkg::SFB_F_SET : sfb_pkg::SFB_F_CLEAR;
         smb_wr_in <= 1'b1;
         smb_val_in <= (i % 3 == 0) ? 4'h0 : (i % 3 == 1) ? 4'h1 : 4'hF;
         raw_addr <= (i < 8) ? 8'h7E + 8'(i % 4) : 8'($random(seed));
         fin(1);
         @(posedge clk_in) acc_valid_in <= 1'b1;
         acc_indirect_in <= 1'($random(seed));
         acc_wide_in <= 1'($random(seed));
         acc_addr_in <= (i % 5 == 0) ? even_addr : raw_addr;
         fin(2);
         x = exp_acc(e, smb_val_in, acc_addr_in, acc_indirect_in, acc_wide_in);
         chk("acc_ok", 13'(x[12]), 13'(acc_ok_out));
         if (x[12]) chk("ram_addr", 13'(x[11:0]), 13'(ram_addr_out));
      end
      final_report;
   end
endmodule
